// ==== core/ipr_port.sv ====
// input-only port: register bank, boot load, pin sampling, pad controls
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module ipr_port
    import ipr_pkg::*;
(
    input  wire logic              mclk,          // system clock, 20 MHz
    input  wire logic              reset,         // async reset, active high
    input  wire logic [ADDR_W-1:0] addr,          // register byte address
    input  wire logic [DATA_W-1:0] wr_data,       // write data
    input  wire logic              wr_en,         // write strobe
    input  wire logic              rd_en,         // read strobe
    output logic      [DATA_W-1:0] rd_data,       // read data, next cycle
    input  wire logic [DATA_W-1:0] pin_in,        // pad receiver levels
    output logic      [DATA_W-1:0] rx_disable,    // receiver off per pin
    output logic      [DATA_W-1:0] pull_up_en,    // pull-up on per pin
    output logic      [DATA_W-1:0] pull_down_en   // pull-down on per pin
);
    // the port has no output driver of any kind

    ipr_state_t        state_reg;
    ipr_state_t        state_next;
    logic [DATA_W-1:0] gate_reg;
    logic [DATA_W-1:0] gate_next;
    logic [DATA_W-1:0] pol_reg;
    logic [DATA_W-1:0] pol_next;
    logic [DATA_W-1:0] en_reg;
    logic [DATA_W-1:0] en_next;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic [DATA_W-1:0] pin_sync;

    // exact decode: a partial one would alias the reserved offsets
    function automatic logic addr_hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] ofs
    );
        addr_hit = (a == ofs);
    endfunction

    // one pin's field taken out of a register word
    function automatic logic field_of(
        input logic [DATA_W-1:0] word,
        input int unsigned       pos
    );
        field_of = word[pos];
    endfunction

    // rebuild a word from the five pin fields; unused slots read zero
    function automatic logic [DATA_W-1:0] pack_pins(
        input logic f0,
        input logic f2,
        input logic f3,
        input logic f4,
        input logic f5
    );
        pack_pins                = ZERO_BYTE;
        pack_pins[PIN_ZERO_POS]  = f0;
        pack_pins[PIN_TWO_POS]   = f2;
        pack_pins[PIN_THREE_POS] = f3;
        pack_pins[PIN_FOUR_POS]  = f4;
        pack_pins[PIN_FIVE_POS]  = f5;
    endfunction

    ipr_pad_if pad_cfg ();

    ipr_sync i_ipr_sync (
        .mclk  (mclk),
        .reset (reset),
        .d_in  (pin_in),
        .q_out (pin_sync)
    );

    ipr_pad_ctrl i_ipr_pad_ctrl (
        .mclk         (mclk),
        .reset        (reset),
        .cfg          (pad_cfg.dst),
        .rx_disable   (rx_disable),
        .pull_up_en   (pull_up_en),
        .pull_down_en (pull_down_en)
    );

    assign pad_cfg.gate     = gate_reg;
    assign pad_cfg.polarity = pol_reg;
    assign pad_cfg.pull_en  = en_reg;

    // address decode; accesses outside the four offsets do nothing
    wire hit_value = addr_hit(addr, OFS_PIN_LEVEL_VALUE);
    wire hit_gate  = addr_hit(addr, OFS_INPUT_RECEIVER_GATE);
    wire hit_pol   = addr_hit(addr, OFS_PULL_POLARITY_SELECT);
    wire hit_en    = addr_hit(addr, OFS_PULL_DEVICE_ENABLE);
    wire in_boot   = (state_reg == IPR_ST_BOOT);
    wire wr_live   = wr_en && !in_boot;
    wire wr_gate   = wr_live && hit_gate;
    wire wr_pol    = wr_live && hit_pol;
    wire wr_pull   = wr_live && hit_en;
    wire rd_value  = rd_en && hit_value;
    wire rd_gate   = rd_en && hit_gate;
    wire rd_pol    = rd_en && hit_pol;
    wire rd_pull   = rd_en && hit_en;

    // synchronised pin levels, one wire per implemented pin
    wire lvl_pin_zero_bit  = field_of(pin_sync, PIN_ZERO_POS);
    wire lvl_pin_two_bit   = field_of(pin_sync, PIN_TWO_POS);
    wire lvl_pin_three_bit = field_of(pin_sync, PIN_THREE_POS);
    wire lvl_pin_four_bit  = field_of(pin_sync, PIN_FOUR_POS);
    wire lvl_pin_five_bit  = field_of(pin_sync, PIN_FIVE_POS);

    wire gate_pin_zero_bit  = field_of(gate_reg, PIN_ZERO_POS);
    wire gate_pin_two_bit   = field_of(gate_reg, PIN_TWO_POS);
    wire gate_pin_three_bit = field_of(gate_reg, PIN_THREE_POS);
    wire gate_pin_four_bit  = field_of(gate_reg, PIN_FOUR_POS);
    wire gate_pin_five_bit  = field_of(gate_reg, PIN_FIVE_POS);

    // a gate field of zero turns the receiver on
    wire rx_on_pin_zero_bit  = !gate_pin_zero_bit;
    wire rx_on_pin_two_bit   = !gate_pin_two_bit;
    wire rx_on_pin_three_bit = !gate_pin_three_bit;
    wire rx_on_pin_four_bit  = !gate_pin_four_bit;
    wire rx_on_pin_five_bit  = !gate_pin_five_bit;

    // a disabled receiver delivers low, so its value bit reads zero
    wire val_pin_zero_bit  = lvl_pin_zero_bit & rx_on_pin_zero_bit;
    wire val_pin_two_bit   = lvl_pin_two_bit & rx_on_pin_two_bit;
    wire val_pin_three_bit = lvl_pin_three_bit & rx_on_pin_three_bit;
    wire val_pin_four_bit  = lvl_pin_four_bit & rx_on_pin_four_bit;
    wire val_pin_five_bit  = lvl_pin_five_bit & rx_on_pin_five_bit;

    wire pol_pin_zero_bit  = field_of(pol_reg, PIN_ZERO_POS);
    wire pol_pin_two_bit   = field_of(pol_reg, PIN_TWO_POS);
    wire pol_pin_three_bit = field_of(pol_reg, PIN_THREE_POS);
    wire pol_pin_four_bit  = field_of(pol_reg, PIN_FOUR_POS);
    wire pol_pin_five_bit  = field_of(pol_reg, PIN_FIVE_POS);

    wire en_pin_zero_bit  = field_of(en_reg, PIN_ZERO_POS);
    wire en_pin_two_bit   = field_of(en_reg, PIN_TWO_POS);
    wire en_pin_three_bit = field_of(en_reg, PIN_THREE_POS);
    wire en_pin_four_bit  = field_of(en_reg, PIN_FOUR_POS);
    wire en_pin_five_bit  = field_of(en_reg, PIN_FIVE_POS);

    // only the five pin fields exist; reserved slots read back zero
    wire [DATA_W-1:0] value_bits = pack_pins(
        val_pin_zero_bit,
        val_pin_two_bit,
        val_pin_three_bit,
        val_pin_four_bit,
        val_pin_five_bit
    );

    wire [DATA_W-1:0] gate_view = pack_pins(
        gate_pin_zero_bit,
        gate_pin_two_bit,
        gate_pin_three_bit,
        gate_pin_four_bit,
        gate_pin_five_bit
    );

    wire [DATA_W-1:0] pol_view = pack_pins(
        pol_pin_zero_bit,
        pol_pin_two_bit,
        pol_pin_three_bit,
        pol_pin_four_bit,
        pol_pin_five_bit
    );

    wire [DATA_W-1:0] en_view = pack_pins(
        en_pin_zero_bit,
        en_pin_two_bit,
        en_pin_three_bit,
        en_pin_four_bit,
        en_pin_five_bit
    );

    // read data falls back to zero in every cycle without a read
    wire [DATA_W-1:0] rd_mux =
        rd_value ? value_bits :
        rd_gate  ? gate_view :
        rd_pol   ? pol_view :
        rd_pull  ? en_view :
                   ZERO_BYTE;

    // write paths; masks keep read-only bits at their stored values
    wire [DATA_W-1:0] gate_wr =
        ipr_merge(gate_reg, wr_data, GATE_WR_MASK);
    wire [DATA_W-1:0] pol_wr =
        ipr_merge(pol_reg, wr_data, POL_WR_MASK);
    wire [DATA_W-1:0] en_wr =
        ipr_merge(en_reg, wr_data, EN_WR_MASK);

    // boot load takes one cycle after release; writes then are dropped
    assign gate_next =
        in_boot ? GATE_BOOT :
        wr_gate ? gate_wr : gate_reg;
    assign pol_next     = wr_pol ? pol_wr : pol_reg;
    assign en_next      = wr_pull ? en_wr : en_reg;
    assign rd_data_next = rd_mux;

    always_comb begin
        unique case (state_reg)
            IPR_ST_BOOT: state_next = IPR_ST_RUN;
            IPR_ST_RUN:  state_next = IPR_ST_RUN;
            default:     state_next = IPR_ST_BOOT;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= IPR_ST_BOOT;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            gate_reg <= GATE_RESET;
        end else begin
            gate_reg <= gate_next;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pol_reg <= POL_RESET;
        end else begin
            pol_reg <= pol_next;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            en_reg <= EN_RESET;
        end else begin
            en_reg <= en_next;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_data_reg <= ZERO_BYTE;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;
endmodule

// ==== core/ipr_pkg.sv ====
// constants shared by the input-only port register bank
// What this block does
// - value bits 0,2,3,4,5 follow the pin level while the pin's gate bit is 0, high reads 1, low 0; gated pins read 0
// - value bits 1, 6 and 7 always read zero
// - gate bit 0 enables a pin's input receiver, 1 disables it
// - after boot the gate register holds 8F hexadecimal before software runs
// - polarity bit 0 selects pull-down, 1 pull-up; resets to BF hexadecimal
// - pull enable bit 1 switches pull device on; resets to 00 hexadecimal
// - the port only receives; it never drives a pin
package ipr_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL_VALUE      = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_INPUT_RECEIVER_GATE  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PULL_POLARITY_SELECT = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_PULL_DEVICE_ENABLE   = 8'h2C;

    // implemented pins: 0, 2, 3, 4, 5
    localparam logic [DATA_W-1:0] PIN_MASK      = 8'h3D;
    // bit position of each implemented pin, the same in every register
    localparam int unsigned PIN_ZERO_POS  = 0;
    localparam int unsigned PIN_TWO_POS   = 2;
    localparam int unsigned PIN_THREE_POS = 3;
    localparam int unsigned PIN_FOUR_POS  = 4;
    localparam int unsigned PIN_FIVE_POS  = 5;
    // bits that hold a written value in each register
    localparam logic [DATA_W-1:0] GATE_WR_MASK  = 8'hBF;
    localparam logic [DATA_W-1:0] POL_WR_MASK   = 8'h3F;
    localparam logic [DATA_W-1:0] EN_WR_MASK    = 8'h3D;

    localparam logic [DATA_W-1:0] GATE_RESET    = 8'hBF;
    localparam logic [DATA_W-1:0] GATE_BOOT     = 8'h8F;
    localparam logic [DATA_W-1:0] POL_RESET     = 8'hBF;
    localparam logic [DATA_W-1:0] EN_RESET      = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;

    localparam int unsigned SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        IPR_ST_BOOT = 2'b01,
        IPR_ST_RUN  = 2'b10
    } ipr_state_t;

    function automatic logic [DATA_W-1:0] ipr_merge(
        input logic [DATA_W-1:0] old_val,
        input logic [DATA_W-1:0] new_val,
        input logic [DATA_W-1:0] wmask
    );
        ipr_merge = (old_val & ~wmask) | (new_val & wmask);
    endfunction
endpackage

// ==== core/ipr_pad_if.sv ====
// pad control bundle between register bank and pad driver stage
`timescale 1ns/10ps
interface ipr_pad_if;
    logic [7:0] gate;
    logic [7:0] polarity;
    logic [7:0] pull_en;

    modport src (output gate, output polarity, output pull_en);
    modport dst (input gate, input polarity, input pull_en);
endinterface

// ==== core/ipr_sync.sv ====
// two-stage synchroniser for the port pin levels
`timescale 1ns/10ps
module ipr_sync
    import ipr_pkg::*;
(
    input  wire logic              mclk,   // system clock
    input  wire logic              reset,  // async reset, active high
    input  wire logic [DATA_W-1:0] d_in,   // asynchronous pin levels
    output logic      [DATA_W-1:0] q_out   // levels in mclk domain
);
    logic [DATA_W-1:0] meta_reg;
    logic [DATA_W-1:0] sync_reg;

    // first stage feeds only the second stage
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_reg <= ZERO_BYTE;
            sync_reg <= ZERO_BYTE;
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;
endmodule

// ==== core/ipr_pad_ctrl.sv ====
// registered pad controls derived from gate, polarity and enable
`timescale 1ns/10ps
module ipr_pad_ctrl
    import ipr_pkg::*;
(
    input  wire logic              mclk,          // system clock
    input  wire logic              reset,         // async reset, active high
    ipr_pad_if.dst                 cfg,           // register contents
    output logic      [DATA_W-1:0] rx_disable,    // receiver off per pin
    output logic      [DATA_W-1:0] pull_up_en,    // pull-up on per pin
    output logic      [DATA_W-1:0] pull_down_en   // pull-down on per pin
);
    logic [DATA_W-1:0] rx_dis_reg;
    logic [DATA_W-1:0] pu_reg;
    logic [DATA_W-1:0] pd_reg;
    wire  [DATA_W-1:0] rx_dis_next;
    wire  [DATA_W-1:0] pu_next;
    wire  [DATA_W-1:0] pd_next;

    // unimplemented pad slots stay receiver-off with no pull
    assign rx_dis_next = (cfg.gate | ~PIN_MASK);
    assign pu_next = cfg.pull_en & cfg.polarity & PIN_MASK;
    assign pd_next = cfg.pull_en & ~cfg.polarity & PIN_MASK;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rx_dis_reg <= GATE_RESET | ~PIN_MASK;
            pu_reg     <= ZERO_BYTE;
            pd_reg     <= ZERO_BYTE;
        end else begin
            rx_dis_reg <= rx_dis_next;
            pu_reg     <= pu_next;
            pd_reg     <= pd_next;
        end
    end

    assign rx_disable   = rx_dis_reg;
    assign pull_up_en   = pu_reg;
    assign pull_down_en = pd_reg;
endmodule

// ==== tb/ipr_pins_model.sv ====
// pin-side model: external drivers, pull devices, floating pads
`timescale 1ns/10ps
module ipr_pins_model (
    input  wire logic       mclk,    // pace of the floating pattern
    input  wire logic [7:0] drv_en,  // external driver on
    input  wire logic [7:0] drv_val, // external driver level
    input  wire logic [7:0] pull_up, // pull-up on
    input  wire logic [7:0] pull_dn, // pull-down on
    output logic      [7:0] level    // resulting pad level
);
    logic [7:0] float_reg = 8'h55;
    // a floating pad wanders, so no test can lean on it
    always_ff @(posedge mclk) float_reg <= ~float_reg;
    assign level = (drv_en & drv_val) | (~drv_en & pull_up)
                 | (~drv_en & ~pull_up & ~pull_dn & float_reg);
endmodule

// ==== tb/ipr_port_chk.sv ====
// port-level assertions for the input-only port
`timescale 1ns/10ps
module ipr_port_chk
    import ipr_pkg::*;
(
    input wire logic       mclk,        // clock
    input wire logic       reset,       // reset
    input wire logic [7:0] addr,        // address
    input wire logic [7:0] wr_data,     // write data
    input wire logic       wr_en,       // write strobe
    input wire logic       rd_en,       // read strobe
    input wire logic [7:0] rd_data,     // read data
    input wire logic [7:0] pin_in,      // pins
    input wire logic [7:0] rx_disable,  // receiver off
    input wire logic [7:0] pull_up_en,  // pull-up
    input wire logic [7:0] pull_down_en // pull-down
);
    logic [1:0] run_reg;
    wire  [7:0] pulls = pull_up_en | pull_down_en;
    // sync stages hold reset values for the first cycles after release
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            run_reg <= 2'h0;
        else if (run_reg != 2'h3)
            run_reg <= run_reg + 2'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_rsv_zero: assert property (rd_en |=> (rd_data & 8'hC2) == 8'h00)
        else $error("reserved bit read nonzero");
    a_pin_follow: assert property (run_reg[1] && rd_en && addr == 8'h10
        |=> rd_data == ($past(pin_in, 3) & ~rx_disable & 8'h3D))
        else $error("pin value wrong");
    a_pad_rsv: assert property ((rx_disable & 8'hC2) == 8'hC2
        && (pulls & 8'hC2) == 8'h00) else $error("unused pad active");
    a_pull_excl: assert property ((pull_up_en & pull_down_en) == 8'h00)
        else $error("both pulls on");
    a_en_write: assert property (run_reg != 2'h0 && wr_en && addr == 8'h2C
        ##1 !wr_en |=> pulls == ($past(wr_data, 2) & 8'h3D))
        else $error("pull enable wrong");
    a_gate_write: assert property (run_reg != 2'h0 && wr_en && addr == 8'h14
        ##1 !wr_en |=> rx_disable == ($past(wr_data, 2) | 8'hC2))
        else $error("receiver gate wrong");
    a_pol_write: assert property (run_reg != 2'h0 && wr_en && addr == 8'h28
        ##1 !wr_en |=> pull_up_en == ($past(wr_data, 2) & pulls))
        else $error("pull polarity wrong");
    a_boot_gate: assert property ($fell(reset) |-> ##2 rx_disable == 8'hCF)
        else $error("boot gate value wrong");
    a_rd_idle: assert property (!rd_en |=> rd_data == 8'h00)
        else $error("read data not idle");
    c_pin_read: cover property (rd_en && addr == 8'h10);
    c_en_write: cover property (wr_en && addr == 8'h2C);
    c_boot_write: cover property ($fell(reset) && wr_en);
    c_both_pulls: cover property (pull_up_en != 8'h00 && pull_down_en != 8'h00);
endmodule
bind ipr_port ipr_port_chk i_ipr_port_chk (.mclk, .reset, .addr, .wr_data,
    .wr_en, .rd_en, .rd_data, .pin_in, .rx_disable, .pull_up_en, .pull_down_en);

// ==== tb/tb_ipr_port.sv ====
// self-checking bench for the input-only port
`timescale 1ns/10ps
module tb_ipr_port
    import ipr_pkg::*;
;
    typedef struct { logic [7:0] a, d, e; } ipr_row_t;
    logic       mclk = 1'h0, reset = 1'h1, wr_en = 1'h0, rd_en = 1'h0;
    logic [7:0] addr = 8'h00, wr_data = 8'h00, drv_en = 8'h00, drv_val = 8'h00;
    logic [7:0] rd_data, pin_in, rx_disable, pull_up_en, pull_down_en;
    logic [7:0] pats [2] = '{8'hD5, 8'h6A};
    int         fails = 0, samples_checked = 0;
    ipr_row_t   rows [6] = '{'{8'h14, 8'hFF, 8'h3D}, '{8'h28, 8'h00, 8'h00},
        '{8'h2C, 8'hFF, 8'h3D}, '{8'h28, 8'hFF, 8'h3D},
        '{8'h40, 8'hFF, 8'h00}, '{8'h10, 8'hFF, 8'h00}};
    ipr_port i_ipr_port (.mclk, .reset, .addr, .wr_data, .wr_en, .rd_en,
        .rd_data, .pin_in, .rx_disable, .pull_up_en, .pull_down_en);
    ipr_pins_model i_ipr_pins_model (.mclk, .drv_en, .drv_val,
        .pull_up(pull_up_en), .pull_dn(pull_down_en), .level(pin_in));
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("mismatch %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'h1;
        @(posedge mclk);
        wr_en <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge mclk);
        rd_en <= 1'h0;
        #1 check(rd_data, e);
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial forever #25 mclk = ~mclk;
    initial begin
        #100000 fails++;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge mclk);
        check(rx_disable, 8'hFF);
        check(pull_up_en | pull_down_en, 8'h00);
        repeat (5) @(posedge mclk);
        reset <= 1'h0;
        rd(8'h28, 8'h3D);
        rd(8'h2C, 8'h00);
        rd(8'h14, 8'h0D);
        check(rx_disable, 8'hCF);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        check(pull_up_en, 8'h3D);
        wr(8'h28, 8'h05);
        wr(8'h14, 8'h00);
        rd(8'h10, 8'h05);
        check(pull_down_en, 8'h38);
        foreach (pats[i]) begin
            @(posedge mclk);
            drv_en <= 8'hFF;
            drv_val <= pats[i];
            repeat (2) @(posedge mclk);
            rd(8'h10, pats[i] & 8'h3D);
        end
        wr(8'h14, 8'h08);
        rd(8'h10, 8'h20);
        @(posedge mclk);
        reset <= 1'h1;
        repeat (2) @(posedge mclk);
        check(rx_disable, 8'hFF);
        reset <= 1'h0;
        addr <= 8'h2C;
        wr_data <= 8'h3D;
        wr_en <= 1'h1;
        @(posedge mclk);
        wr_en <= 1'h0;
        rd(8'h2C, 8'h00);
        check(rx_disable, 8'hCF);
        check(pull_up_en | pull_down_en, 8'h00);
        rd(8'h28, 8'h3D);
        end_sim;
    end
endmodule
